// ===== bench/adc_sweep_channel_config_test.sv
/*
 * self-checking bench of the sweep block: apb master, converter model, result checks.
 * assumes ascc_params.svh on the include path and a 25 MHz ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ascc_params.svh"

module adc_sweep_channel_config_test;
    // ****************************************
    // signals and counters
    // ****************************************
    logic        ref_clk    = 1'b0;
    logic        sys_rst    = 1'b1;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [11:0] paddr      = 12'h000;
    logic [31:0] pwdata     = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        conv_done;
    logic [11:0] conv_data;
    logic        conv_start;
    logic        sampling;
    logic [1:0]  conv_chan;
    logic        conv_diff;
    logic        irq;
    logic [64:0] note_q[$];
    logic [64:0] nt;
    logic [1:0]  ch;
    logic [1:0]  prev;
    logic        df;
    logic        s0;
    integer      seed       = 32'h9f46;
    int          fail_count = 0;
    int          cmp_count  = 0;
    int          cyc        = 0;
    int          len;
    int          hit;
    logic [31:0] v;

    ascc_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_done(conv_done), .conv_data(conv_data),
        .conv_start(conv_start), .sampling(sampling), .conv_chan(conv_chan),
        .conv_diff(conv_diff), .irq(irq));

    ascc_conv_model conv_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .conv_start(conv_start),
        .conv_done(conv_done), .conv_data(conv_data));

    initial forever #20 ref_clk = ~ref_clk;

    // ****************************************
    // checking and closing
    // ****************************************
    task stop_test;
        if (fail_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function logic [11:0] smp(input int k);
        return 12'h5a3 + 12'(k * 37);
    endfunction

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    // answers to reads and writes alike are taken off the note queue in issue order
    always @(posedge ref_clk) begin
        if (pready === 1'b1) begin
            nt = note_q.pop_front();
            check({31'h0, pslverr}, {31'h0, nt[0]});
            check(prdata & nt[64:33], nt[32:1]);
        end
    end

    // ****************************************
    // apb master and window measurement
    // ****************************************
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [31:0] m, input logic [31:0] e, input logic er);
        note_q.push_back({m, e, er});
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 32'hffffffff, e, 1'b0);
    endtask

    task win(output int n, output logic [1:0] c, output logic d);
        @(posedge ref_clk);
        while (sampling !== 1'b1) @(posedge ref_clk);
        c = conv_chan;
        d = conv_diff;
        n = 0;
        while (sampling === 1'b1) begin
            @(posedge ref_clk);
            n++;
        end
        check({31'h0, conv_start}, 32'h1);
    endtask

    // window of p periods of the 1.28 MHz tick, the first one partial
    task span(input int p, input int n);
        check(32'((n > (p - 1) * 2500 / 128) && (n <= (p * 2500 + 127) / 128 + 3)), 32'h1);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`ASCC_OFF_CTRL, {30'h0, `ASCC_CTRL_RESET});
        rd(`ASCC_OFF_PAIR_B, 32'h0);
        rd(`ASCC_OFF_PAIR_C, 32'h0);
        rd(`ASCC_OFF_IST, 32'h0);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 32'h0, 1'b1);
        apb(1'b1, `ASCC_OFF_IST, 32'hffffffff, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h400, 32'hffffffff, 32'h0, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(i[0] ? `ASCC_OFF_PAIR_C : `ASCC_OFF_PAIR_B, v);
            rd(i[0] ? `ASCC_OFF_PAIR_C : `ASCC_OFF_PAIR_B, v & 32'h007f007f);
        end
        wr(`ASCC_OFF_PAIR_B, 32'h35);
        wr(`ASCC_OFF_PAIR_C, 32'h0);
        hit = 0;
        repeat (300) begin
            @(posedge ref_clk);
            if (sampling !== 1'b0) hit++;
        end
        check(32'(hit), 32'h0);
        wr(`ASCC_OFF_CTRL, 32'h0);
        win(len, ch, df);
        check({30'h0, ch}, 32'h0);
        check({31'h0, df}, 32'h1);
        span(22, len);
        wr(`ASCC_OFF_CTRL, 32'h1);
        wr(`ASCC_OFF_CTRL, 32'h2);
        win(len, ch, df);
        span(23, len);
        wr(`ASCC_OFF_CTRL, 32'h1);
        wr(`ASCC_OFF_PAIR_B, 32'h10);
        wr(`ASCC_OFF_PAIR_C, 32'h0010_0000);
        wr(`ASCC_OFF_CTRL, 32'h0);
        prev = 2'h1;
        for (int i = 0; i < 4; i++) begin
            win(len, ch, df);
            check({30'h0, ch == 2'h0 || ch == 2'h3, ch != prev}, 32'h3);
            check({31'h0, df}, 32'h0);
            span(2, len);
            prev = ch;
        end
        wr(`ASCC_OFF_CTRL, 32'h1);
        wr(`ASCC_OFF_PAIR_B, 32'h0);
        wr(`ASCC_OFF_PAIR_C, 32'h0050_0000);
        wr(`ASCC_OFF_CTRL, 32'h0);
        hit = 0;
        s0  = 1'b0;
        repeat (1000) begin
            @(posedge ref_clk);
            if (sampling === 1'b1 && s0 !== 1'b1) hit++;
            s0 = sampling;
        end
        check(32'(hit), 32'h1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wr(`ASCC_OFF_IEN, 32'h1);
        wr(`ASCC_OFF_PAIR_B, 32'h10);
        wr(`ASCC_OFF_CTRL, 32'h0);
        while (irq !== 1'b1) @(posedge ref_clk);
        check(32'(conv_u.k), 32'd64);
        wr(`ASCC_OFF_CTRL, 32'h1);
        rd(`ASCC_OFF_IST, 32'h1);
        wr(`ASCC_OFF_IEN, 32'h0);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h0);
        wr(`ASCC_OFF_IEN, 32'h1);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h1);
        wr(`ASCC_OFF_ICLR, 32'h1);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h0);
        rd(`ASCC_OFF_IST, 32'h0);
        rd(12'h400, {4'h0, smp(1), 4'h0, smp(0)});
        rd(12'h47c, {4'h0, smp(63), 4'h0, smp(62)});
        repeat (2) @(posedge ref_clk);
        stop_test();
    end
endmodule // adc_sweep_channel_config_test

`default_nettype wire

// ===== bench/ascc_conv_model.sv
/*
 * converter model on the far side of the sweep block: answers each start with a result.
 * assumes conv_start is a one-cycle pulse on ref_clk and sys_rst clears the result count.
 */
`timescale 1ns/1ps
`default_nettype none

module ascc_conv_model (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        conv_start,
    output logic             conv_done,
    output logic      [11:0] conv_data
);
    // ****************************************
    // conversion timing and result pattern
    // ****************************************
    int   k      = 0;
    int   wait_c = 0;
    logic busy   = 1'b0;

    initial conv_done = 1'b0;
    initial conv_data = 12'h000;

    // odd results answer slowly, even ones promptly; the data bus toggles when idle
    always @(posedge ref_clk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (sys_rst) begin
            k    <= 0;
            busy <= 1'b0;
        end else if (conv_start) begin
            busy   <= 1'b1;
            wait_c <= k[0] ? 20 : 2;
        end else if (busy && wait_c == 0) begin
            conv_done <= 1'b1;
            conv_data <= 12'h5a3 + 12'(k * 37);
            k         <= k + 1;
            busy      <= 1'b0;
        end else if (busy) begin
            wait_c <= wait_c - 1;
        end
    end
endmodule // ascc_conv_model

`default_nettype wire

// ===== hdl/ascc_mem.sv
/*
 * result memory: two 16-bit sample slots per word, registered read.
 * assumes one writer and one reader on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ascc_mem #(
    parameter int AW = 7
) (
    input  wire logic          ref_clk,
    input  wire logic [1:0]    we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [31:0]   wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [31:0]   rdata
);
    logic [31:0] mem [0:(1<<AW)-1];

    always_ff @(posedge ref_clk) begin
        if (we[0]) mem[waddr][15:0] <= wdata[15:0];
        if (we[1]) mem[waddr][31:16] <= wdata[31:16];
        rdata <= mem[raddr];
    end
endmodule // ascc_mem
`default_nettype wire

// ===== hdl/ascc_params.svh
/*
 * constants of the sweep channel configuration block: offsets, fields, resets, timing.
 * assumes inclusion by bare name from files that need them.
 */
`ifndef ASCC_PARAMS_SVH
`define ASCC_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define ASCC_OFF_CTRL      12'h000
`define ASCC_OFF_IST       12'h004
`define ASCC_OFF_ICLR      12'h008
`define ASCC_OFF_IEN       12'h00c
`define ASCC_OFF_PAIR_B    12'h074
`define ASCC_OFF_PAIR_C    12'h078
`define ASCC_MEM_REGION    3'h2
`define ASCC_CTRL_RESET    2'h1

// ****************************************
// field positions
// ****************************************
`define ASCC_CTRL_OVR      0
`define ASCC_CTRL_RATE     1
`define ASCC_FLD_EN        4
`define ASCC_FLD_DIFF      5
`define ASCC_FLD_ONE       6
`define ASCC_HI_LSB        16

// ****************************************
// timing
// ****************************************
`define ASCC_REF_KHZ       25000
`define ASCC_T_KHZ         1280
`define ASCC_TICK_INC      12'((`ASCC_T_KHZ) / 10)
`define ASCC_TICK_MOD      12'((`ASCC_REF_KHZ) / 10)
`define ASCC_BASE_320K     6'h2
`define ASCC_BASE_256K     6'h3
`define ASCC_RESULT_BYTES  128
`define ASCC_SAMPLE_BYTES  2

`endif

// ===== hdl/ascc_pkg.sv
/*
 * types of the sweep channel configuration block.
 * assumes ascc_params.svh for numeric constants.
 */
package ascc_pkg;
    typedef enum logic [1:0] {ASCC_IDLE, ASCC_SAMPLE, ASCC_CONV} ascc_state_t;
    typedef logic [6:0] ascc_chcfg_t;
    typedef struct packed {
        ascc_chcfg_t [3:0]  cfg;
        logic               ovr;
        logic               rate;
        logic [3:0]         ien;
        logic [3:0]         ist;
        logic [3:0]         shot_done;
        ascc_state_t        state;
        logic [1:0]         cur;
        logic [5:0]         cnt;
        logic [3:0][5:0]    wptr;
        logic               conv_start;
        logic               sampling;
        logic [1:0]         conv_chan;
        logic               conv_diff;
        logic               irq;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        logic [1:0]         mem_we;
        logic [6:0]         mem_waddr;
        logic [31:0]        mem_wdata;
    } ascc_state_s_t;
endpackage

// ===== hdl/ascc_tick.sv
/*
 * sample time base: one-cycle tick at the mean rate of the sample clock.
 * assumes ref_clk at the rate set in ascc_params.svh.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ascc_params.svh"

module ascc_tick #(
    parameter logic [11:0] INC = `ASCC_TICK_INC,
    parameter logic [11:0] MOD = `ASCC_TICK_MOD
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    output logic      tick
);
    typedef struct packed {
        logic [11:0] acc;
        logic        tick;
    } ascc_tick_s_t;

    ascc_tick_s_t q;
    ascc_tick_s_t d;
    logic [12:0]  sum;

    // phase accumulator, one tick per sample clock period
    always_comb begin
        d   = q;
        sum = {1'b0, q.acc} + {1'b0, INC};
        if (sum >= {1'b0, MOD}) begin
            d.acc  = 12'(sum - {1'b0, MOD});
            d.tick = 1'b1;
        end else begin
            d.acc  = sum[11:0];
            d.tick = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) q <= '0;
        else q <= d;
    end

    assign tick = q.tick;

    tick_spacing_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        q.tick |=> !q.tick) else $error("tick lasted two cycles"); // RL3
endmodule // ascc_tick
`default_nettype wire

// ===== hdl/ascc_top.sv
/*
 * automatic sweep channel configuration, sequencer and result store behind APB.
 * assumes the converter front end runs on ref_clk and answers a start with conv_done.
 */
// Implementation choice: the APB slave port.
// Notes on behaviour
// RL1: 320k rate: code gives 2T to 62T
// RL2: 256k rate: code gives 3T to 63T
// RL3: T is one 1.28 MHz period
// RL4: bit 4 enables; sweep skips disabled channels
// RL5: bit 5: one differential, zero single-ended
// RL6: bit 6: zero continuous, one single shot
// RL7: fields act only in automatic sweep mode
// RL8: low half positive, high half negative channel
// RL9: offset 0x74 holds pair B channels
// RL10: offset 0x78 holds pair C channels
// RL11: override bit zero runs automatic sweep
// RL12: 128-byte area per channel, full raises flag
// RL13: each 12-bit result takes two bytes
// RL14: linear code map; bits 15:7 read zero
`timescale 1ns/1ps
`default_nettype none
`include "ascc_params.svh"

module ascc_top
    import ascc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    output logic             conv_start,
    output logic             sampling,
    output logic      [1:0]  conv_chan,
    output logic             conv_diff,
    output logic             irq
);
    // ****************************************
    // declarations
    // ****************************************
    ascc_state_s_t q;
    ascc_state_s_t d;
    logic          tick;
    logic [31:0]   mem_rdata;
    logic          acc_cyc;
    logic          xfer_done;
    logic          in_mem;
    logic [3:0]    ist_set;
    logic [3:0]    ist_clr;
    logic [3:0]    elig;
    logic [3:0]    elig_after;
    logic [2:0]    pick;
    logic [2:0]    pick_after;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [5:0] periods(input logic rate, input ascc_chcfg_t c);
        logic [5:0] base;
        base = rate ? `ASCC_BASE_256K : `ASCC_BASE_320K; // RL1 RL2
        return base + {c[3:0], 2'b00}; // RL14
    endfunction

    function automatic logic [2:0] next_ch(input logic [3:0] el, input logic [1:0] from);
        logic [2:0] r;
        logic [1:0] c;
        r = 3'h0;
        for (int i = 4; i >= 1; i--) begin
            c = 2'(from + 2'(i));
            if (el[c]) r = {1'b1, c};
        end
        return r;
    endfunction

    function automatic logic [15:0] cfg_half(input ascc_chcfg_t c);
        return {9'h000, c}; // RL14
    endfunction

    // ****************************************
    // sub blocks
    // ****************************************
    ascc_tick u_tick (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    ascc_mem #(.AW(7)) u_mem (
        .ref_clk (ref_clk),
        .we      (q.mem_we),
        .waddr   (q.mem_waddr),
        .wdata   (q.mem_wdata),
        .raddr   (paddr[8:2]),
        .rdata   (mem_rdata)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d            = q;
        d.pready     = 1'b0;
        d.pslverr    = 1'b0;
        d.conv_start = 1'b0;
        d.mem_we     = 2'b00;
        ist_set      = 4'h0;
        ist_clr      = 4'h0;
        acc_cyc      = psel && penable && !q.pready;
        xfer_done    = psel && penable && q.pready;
        in_mem       = (paddr[11:9] == `ASCC_MEM_REGION);

        // apb answer, one wait state
        if (acc_cyc) begin
            d.pready = 1'b1;
            d.prdata = 32'h0;
            if (in_mem) begin
                d.prdata  = mem_rdata;
                d.pslverr = pwrite;
            end else begin
                unique case (paddr)
                    `ASCC_OFF_CTRL: d.prdata = {30'h0, q.rate, q.ovr};
                    `ASCC_OFF_IST: d.prdata = {28'h0, q.ist};
                    `ASCC_OFF_ICLR: d.prdata = 32'h0;
                    `ASCC_OFF_IEN: d.prdata = {28'h0, q.ien};
                    `ASCC_OFF_PAIR_B: d.prdata = {cfg_half(q.cfg[1]), cfg_half(q.cfg[0])}; // RL9
                    `ASCC_OFF_PAIR_C: d.prdata = {cfg_half(q.cfg[3]), cfg_half(q.cfg[2])}; // RL10
                    default: d.pslverr = 1'b1;
                endcase
                if (pwrite && paddr == `ASCC_OFF_IST) d.pslverr = 1'b1;
            end
        end

        // apb write takes effect at the completing edge
        if (xfer_done && pwrite && !q.pslverr) begin
            unique case (paddr)
                `ASCC_OFF_CTRL: begin
                    d.ovr = pwdata[`ASCC_CTRL_OVR]; // RL11
                    d.rate = pwdata[`ASCC_CTRL_RATE];
                end
                `ASCC_OFF_ICLR: ist_clr = pwdata[3:0];
                `ASCC_OFF_IEN: d.ien = pwdata[3:0];
                `ASCC_OFF_PAIR_B: begin
                    d.cfg[0] = pwdata[6:0]; // RL8 RL9
                    d.cfg[1] = pwdata[`ASCC_HI_LSB +: 7]; // RL8 RL9
                    d.shot_done[1:0] = 2'b00;
                end
                `ASCC_OFF_PAIR_C: begin
                    d.cfg[2] = pwdata[6:0]; // RL8 RL10
                    d.cfg[3] = pwdata[`ASCC_HI_LSB +: 7]; // RL8 RL10
                    d.shot_done[3:2] = 2'b00;
                end
                default: ;
            endcase
        end

        // channel eligibility
        for (int c = 0; c < 4; c++) begin
            elig[c] = q.cfg[c][`ASCC_FLD_EN] &&
                      !(q.cfg[c][`ASCC_FLD_ONE] && q.shot_done[c]); // RL4 RL6
        end
        elig_after = elig;
        if (q.cfg[q.cur][`ASCC_FLD_ONE]) elig_after[q.cur] = 1'b0; // RL6
        pick       = next_ch(elig, q.cur);
        pick_after = next_ch(elig_after, q.cur);

        // sweep sequencer
        if (q.ovr) begin
            d.state    = ASCC_IDLE; // RL7
            d.sampling = 1'b0;
        end else begin
            unique case (q.state)
                ASCC_IDLE: begin
                    if (pick[2]) begin
                        d.state     = ASCC_SAMPLE; // RL11
                        d.cur       = pick[1:0];
                        d.cnt       = 6'h0;
                        d.sampling  = 1'b1;
                        d.conv_chan = pick[1:0];
                        d.conv_diff = q.cfg[pick[1:0]][`ASCC_FLD_DIFF]; // RL5
                    end
                end
                ASCC_SAMPLE: begin
                    if (tick) begin // RL3
                        if (q.cnt + 6'h1 == periods(q.rate, q.cfg[q.cur])) begin
                            d.state      = ASCC_CONV;
                            d.conv_start = 1'b1;
                            d.sampling   = 1'b0;
                        end else begin
                            d.cnt = q.cnt + 6'h1;
                        end
                    end
                end
                ASCC_CONV: begin
                    if (conv_done) begin
                        d.mem_we    = q.wptr[q.cur][0] ? 2'b10 : 2'b01; // RL13
                        d.mem_waddr = {q.cur, q.wptr[q.cur][5:1]}; // RL13
                        d.mem_wdata = {4'h0, conv_data, 4'h0, conv_data}; // RL13
                        d.wptr[q.cur] = q.wptr[q.cur] + 6'h1;
                        if (q.wptr[q.cur] == 6'h3f) ist_set[q.cur] = 1'b1; // RL12
                        if (q.cfg[q.cur][`ASCC_FLD_ONE]) d.shot_done[q.cur] = 1'b1; // RL6
                        if (pick_after[2]) begin
                            d.state     = ASCC_SAMPLE;
                            d.cur       = pick_after[1:0];
                            d.cnt       = 6'h0;
                            d.sampling  = 1'b1;
                            d.conv_chan = pick_after[1:0];
                            d.conv_diff = q.cfg[pick_after[1:0]][`ASCC_FLD_DIFF]; // RL5
                        end else begin
                            d.state = ASCC_IDLE;
                        end
                    end
                end
                default: d.state = ASCC_IDLE;
            endcase
        end

        // interrupt status, set wins over clear
        d.ist = (q.ist & ~ist_clr) | ist_set; // RL12
        d.irq = |(d.ist & d.ien);
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q      <= '0;
            q.ovr  <= 1'(`ASCC_CTRL_RESET);
            q.rate <= 1'(`ASCC_CTRL_RESET >> 1);
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata     = q.prdata;
    assign pready     = q.pready;
    assign pslverr    = q.pslverr;
    assign conv_start = q.conv_start;
    assign sampling   = q.sampling;
    assign conv_chan  = q.conv_chan;
    assign conv_diff  = q.conv_diff;
    assign irq        = q.irq;

    // ****************************************
    // checks
    // ****************************************
    logic [5:0]  tick_cnt;
    logic [5:0]  exp_per;
    logic [3:0]  prev_full;
    logic [31:0] wdata_q;

    always_ff @(posedge ref_clk) begin
        if (sys_rst || q.state != ASCC_SAMPLE) tick_cnt <= 6'h0;
        else if (tick) tick_cnt <= tick_cnt + 6'h1;
    end

    assign exp_per = periods(q.rate, q.cfg[q.conv_chan]);

    sequence apb_access_s;
        psel && penable && !pready;
    endsequence

    sequence apb_answer_s;
        psel && penable && pready;
    endsequence

    apb_wait_one_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        apb_access_s |=> apb_answer_s ##1 !pready)
        else $error("apb answer not one wait state");

    sample_len_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL1 RL2 RL3
        conv_start |-> ($past(tick_cnt) + 6'h1 == exp_per) && $past(tick))
        else $error("sample window length wrong");

    skip_disabled_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL4
        $rose(sampling) && $stable(q.cfg) |-> q.cfg[conv_chan][`ASCC_FLD_EN])
        else $error("disabled channel sampled");

    diff_select_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL5
        $rose(sampling) && $stable(q.cfg)
        |-> conv_diff == q.cfg[conv_chan][`ASCC_FLD_DIFF])
        else $error("input type does not follow config");

    one_shot_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL6
        conv_done && q.state == ASCC_CONV && !q.ovr && q.cfg[q.cur][`ASCC_FLD_ONE]
        |=> q.shot_done[$past(q.cur)])
        else $error("single shot not recorded");

    manual_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL7
        q.ovr |=> q.state == ASCC_IDLE && !sampling ##1 !conv_start)
        else $error("sweep active in manual mode");

    start_after_sample_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL11
        conv_start |-> $past(sampling) && !sampling ##1 !conv_start)
        else $error("start not after sampling");

    always_ff @(posedge ref_clk) begin
        if (sys_rst) prev_full <= 4'h0;
        else prev_full <= q.ist;
        wdata_q <= pwdata;
    end

    full_only_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL12
        !(q.state == ASCC_CONV && conv_done && !q.ovr && q.wptr[q.cur] == 6'h3f)
        |=> (q.ist & ~prev_full) == 4'h0)
        else $error("full flag set without a full area");

    full_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL12
        q.state == ASCC_CONV && conv_done && !q.ovr && q.wptr[q.cur] == 6'h3f
        |=> q.ist[$past(q.cur)] ##1 irq == |(q.ist & q.ien))
        else $error("full flag not raised");

    slot_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL13
        q.state == ASCC_CONV && conv_done && !q.ovr
        |=> q.mem_we != 2'b11 && q.mem_we != 2'b00 && q.mem_wdata[11:0] == $past(conv_data))
        else $error("result slot write wrong");

    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL14
        pready && !pwrite && (paddr == `ASCC_OFF_PAIR_B || paddr == `ASCC_OFF_PAIR_C)
        |-> prdata[15:7] == 9'h000 && prdata[31:23] == 9'h000)
        else $error("reserved bits not zero");

    pair_b_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL8 RL9
        psel && penable && pready && pwrite && paddr == `ASCC_OFF_PAIR_B
        |=> q.cfg[0] == wdata_q[6:0] && q.cfg[1] == wdata_q[22:16])
        else $error("pair b write lost");

    pair_c_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL8 RL10
        psel && penable && pready && pwrite && paddr == `ASCC_OFF_PAIR_C
        |=> q.cfg[2] == wdata_q[6:0] && q.cfg[3] == wdata_q[22:16])
        else $error("pair c write lost");

    ctrl_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL11
        psel && penable && pready && pwrite && paddr == `ASCC_OFF_CTRL
        |=> q.ovr == wdata_q[`ASCC_CTRL_OVR] && q.rate == wdata_q[`ASCC_CTRL_RATE])
        else $error("control write lost");

    chan_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL5
        sampling && $past(sampling) |-> $stable(conv_chan) && $stable(conv_diff))
        else $error("channel changed inside window");
endmodule // ascc_top
`default_nettype wire
